// ---- src/card_host_ctrl.sv ----
// Control and status side of a removable flash card's host interface.
// Assumes the card core supplies busy, interrupt and transfer-width levels
// synchronous to mclk_i; host pins arrive asynchronous and are synchronised.
`timescale 1ns/1ps
`include "card_host_regs.svh"
module card_host_ctrl
  import card_host_pkg::*;
#(
  parameter int INIT_CYCLES = `INIT_CYCLES_DEF,
  parameter int PULSE_CYCLES = `IRQ_PULSE_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic card_reset_i,
  input wire logic disk_mode_select_n_i,
  input wire logic space_select_n_i,
  input wire logic card_enable_even_n_i,
  input wire logic card_enable_odd_n_i,
  input wire logic addr0_i,
  input wire logic write_enable_n_i,
  input wire logic io_write_strobe_n_i,
  input wire logic dma_acknowledge_n_i,
  input wire logic task_file_select_n_i,
  input wire logic control_block_select_n_i,
  input wire logic [15:0] host_data_i,
  input wire logic io_mode_i,
  input wire logic busy_i,
  input wire logic irq_i,
  input wire logic irq_pulse_mode_i,
  input wire logic dma_enable_i,
  input wire logic dma_request_i,
  input wire logic port_wide_i,
  input wire logic word_xfer_i,
  output logic ready_irq_o,
  output logic wide_n_o,
  output logic write_protect_o,
  output logic io_channel_ready_o,
  output logic [1:0] card_mode_o,
  output logic common_wr_o,
  output logic attr_wr_o,
  output logic io_reg_wr_o,
  output logic task_file_wr_o,
  output logic control_block_wr_o,
  output logic dma_wr_o,
  output logic dma_start_o,
  output logic [1:0] wr_lanes_o,
  output logic [15:0] wr_data_o
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_init
    $error("card_host_ctrl: INIT_CYCLES out of range 1..65535");
  end
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin : g_bad_pulse
    $error("card_host_ctrl: PULSE_CYCLES out of range 1..255");
  end

  localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);
  localparam logic [7:0] PULSE_LOAD = 8'(PULSE_CYCLES);
  localparam logic [1:0] BOOT_LAST = 2'(`BOOT_CYCLES - 1);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [`PIN_W-1:0] pins_s;

  pin_sync #(
    .WIDTH(`PIN_W),
    .RST_VAL(`PIN_IDLE)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .pins_i({host_data_i, card_reset_i, disk_mode_select_n_i, space_select_n_i,
             card_enable_even_n_i, card_enable_odd_n_i, addr0_i, write_enable_n_i,
             io_write_strobe_n_i, dma_acknowledge_n_i, task_file_select_n_i,
             control_block_select_n_i}), // see RQ26
    .pins_o(pins_s)
  );

  wire [15:0] data_s = pins_s[`PIN_DATA_LSB +: 16];
  wire rst_pin_s = pins_s[`PIN_RST];
  wire dsel_n_s = pins_s[`PIN_DSEL];
  wire space_n_s = pins_s[`PIN_SPACE];
  wire ce_even_n_s = pins_s[`PIN_CE_EVEN];
  wire ce_odd_n_s = pins_s[`PIN_CE_ODD];
  wire a0_s = pins_s[`PIN_A0];
  wire we_n_s = pins_s[`PIN_WE];
  wire io_write_strobe_n_n_s = pins_s[`PIN_IO_WRITE_STROBE_N];
  wire dma_acknowledge_n_n_s = pins_s[`PIN_DMA_ACKNOWLEDGE_N];
  wire cs0_n_s = pins_s[`PIN_CS0];
  wire cs1_n_s = pins_s[`PIN_CS1];

  // ----------------------------------------------------------------
  // Lane decode
  // ----------------------------------------------------------------
  // Bit 0 even byte, bit 1 odd byte
  function automatic logic [1:0] lane_sel(input logic ce_e_n, input logic ce_o_n,
                                          input logic a0);
    logic [1:0] sel;
    sel = 2'b00;
    case ({ce_e_n, ce_o_n})
      2'b00: sel = 2'b11;
      2'b01: sel = a0 ? 2'b10 : 2'b01;
      2'b10: sel = 2'b10;
      default: sel = 2'b00;
    endcase
    return sel;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  init_state_t st_ff, nxt_st;
  logic disk_ff, nxt_disk;
  logic [1:0] boot_cnt_ff, nxt_boot_cnt;
  logic [15:0] init_cnt_ff, nxt_init_cnt;
  logic [7:0] pulse_cnt_ff, nxt_pulse_cnt;
  logic irq_d_ff;
  logic we_d_ff;
  logic io_write_strobe_n_d_ff;
  logic dma_acknowledge_n_d_ff;

  card_mode_t mode;
  assign mode = disk_ff ? MODE_DISK : (io_mode_i ? MODE_IO : MODE_MEM);

  wire in_mem = (mode == MODE_MEM);
  wire in_io = (mode == MODE_IO);
  wire in_disk = (mode == MODE_DISK);
  wire running = (st_ff == ST_RUN);

  // Polarity of the reset pin follows the strapped mode
  wire rst_act = disk_ff ? !rst_pin_s : rst_pin_s; // see RQ12 see RQ14
  wire boot_rst_act = !dsel_n_s ? !rst_pin_s : rst_pin_s;

  // ----------------------------------------------------------------
  // Boot, reset and initialisation sequence
  // ----------------------------------------------------------------
  // Mode strap is taken once the synchroniser has settled after nrst_i
  always_comb begin
    nxt_st = st_ff;
    nxt_disk = disk_ff;
    nxt_boot_cnt = boot_cnt_ff;
    nxt_init_cnt = init_cnt_ff;
    case (st_ff)
      ST_BOOT: begin
        nxt_boot_cnt = boot_cnt_ff + 2'b01;
        if (boot_cnt_ff == BOOT_LAST) begin
          nxt_disk = !dsel_n_s; // see RQ24
          nxt_init_cnt = 16'h0000;
          nxt_st = boot_rst_act ? ST_HELD : ST_INIT; // see RQ4 see RQ13
        end
      end
      ST_HELD: begin
        if (!rst_act) begin
          nxt_st = ST_INIT;
        end
      end
      ST_INIT: begin
        if (rst_act) begin
          nxt_init_cnt = 16'h0000;
        end else if (init_cnt_ff == INIT_LAST) begin
          nxt_st = ST_RUN;
        end else begin
          nxt_init_cnt = init_cnt_ff + 16'h0001;
        end
      end
      ST_RUN: begin
        if (rst_act) begin
          nxt_st = ST_INIT; // see RQ2
          nxt_init_cnt = 16'h0000;
        end
      end
      default: nxt_st = ST_BOOT;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= ST_BOOT;
      disk_ff <= 1'b0;
      boot_cnt_ff <= 2'b00;
      init_cnt_ff <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      disk_ff <= nxt_disk;
      boot_cnt_ff <= nxt_boot_cnt;
      init_cnt_ff <= nxt_init_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Strobe edges and write decode
  // ----------------------------------------------------------------
  wire we_rise = !we_d_ff && we_n_s;
  wire io_write_strobe_n_rise = !io_write_strobe_n_d_ff && io_write_strobe_n_n_s;
  wire card_sel = !ce_even_n_s || !ce_odd_n_s;
  wire dma_ack = dma_enable_i && !dma_acknowledge_n_n_s; // see RQ10
  wire dma_ack_fall = dma_enable_i && dma_acknowledge_n_d_ff && !dma_acknowledge_n_n_s;

  wire nxt_common = running && in_mem && we_rise && card_sel && space_n_s; // see RQ7 see RQ16
  wire nxt_attr = running && (in_mem || in_io) && we_rise && card_sel
                  && !space_n_s; // see RQ7 see RQ17
  wire nxt_io_reg = running && in_io && io_write_strobe_n_rise && card_sel && !space_n_s; // see RQ25
  // Selects are disregarded while the DMA acknowledge is honoured
  wire nxt_dma_wr = running && in_disk && io_write_strobe_n_rise && dma_ack; // see RQ23
  wire nxt_task = running && in_disk && io_write_strobe_n_rise && !dma_ack && !cs0_n_s; // see RQ25
  wire nxt_ctrl = running && in_disk && io_write_strobe_n_rise && !dma_ack && !cs1_n_s;
  wire nxt_dma_start = running && in_disk && dma_ack_fall && dma_request_i; // see RQ9
  wire any_wr = nxt_common || nxt_attr || nxt_io_reg || nxt_dma_wr || nxt_task
                || nxt_ctrl;

  wire [1:0] card_lanes = lane_sel(ce_even_n_s, ce_odd_n_s, a0_s); // see RQ22
  wire odd_on_low = !ce_even_n_s && ce_odd_n_s && a0_s;
  wire [1:0] nxt_lanes = in_disk ? 2'b11 : card_lanes;
  wire [15:0] nxt_data = (!in_disk && odd_on_low) ? {data_s[7:0], data_s[7:0]} : data_s;

  // ----------------------------------------------------------------
  // Shared ready / interrupt pin and status outputs
  // ----------------------------------------------------------------
  wire irq_rise = irq_i && !irq_d_ff;
  assign nxt_pulse_cnt = (in_io && irq_pulse_mode_i && irq_rise && running) ? PULSE_LOAD
                         : (pulse_cnt_ff != 8'h00) ? pulse_cnt_ff - 8'h01 : 8'h00;

  wire ready_lvl = (st_ff == ST_HELD) || (running && !busy_i); // see RQ1 see RQ4
  wire io_irq_n = irq_pulse_mode_i ? (pulse_cnt_ff == 8'h00) : !irq_i; // see RQ5
  wire nxt_pin = in_disk ? irq_i : (in_io ? io_irq_n : ready_lvl); // see RQ6
  wire nxt_wide_n = in_io ? !port_wide_i
                    : (in_disk ? !word_xfer_i : 1'b1); // see RQ20 see RQ21
  wire nxt_wp = !running; // see RQ19

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_d_ff <= 1'b0;
      we_d_ff <= 1'b1;
      io_write_strobe_n_d_ff <= 1'b1;
      dma_acknowledge_n_d_ff <= 1'b1;
      pulse_cnt_ff <= 8'h00;
      ready_irq_o <= 1'b0;
      wide_n_o <= 1'b1;
      write_protect_o <= 1'b1;
      io_channel_ready_o <= 1'b1;
      card_mode_o <= MODE_MEM;
    end else begin
      irq_d_ff <= irq_i;
      we_d_ff <= we_n_s;
      io_write_strobe_n_d_ff <= io_write_strobe_n_n_s;
      dma_acknowledge_n_d_ff <= dma_acknowledge_n_n_s;
      pulse_cnt_ff <= nxt_pulse_cnt;
      ready_irq_o <= nxt_pin;
      wide_n_o <= nxt_wide_n;
      write_protect_o <= nxt_wp;
      io_channel_ready_o <= 1'b1; // see RQ15
      card_mode_o <= mode;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      common_wr_o <= 1'b0;
      attr_wr_o <= 1'b0;
      io_reg_wr_o <= 1'b0;
      task_file_wr_o <= 1'b0;
      control_block_wr_o <= 1'b0;
      dma_wr_o <= 1'b0;
      dma_start_o <= 1'b0;
      wr_lanes_o <= 2'b00;
      wr_data_o <= 16'h0000;
    end else begin
      common_wr_o <= nxt_common;
      attr_wr_o <= nxt_attr;
      io_reg_wr_o <= nxt_io_reg;
      task_file_wr_o <= nxt_task;
      control_block_wr_o <= nxt_ctrl;
      dma_wr_o <= nxt_dma_wr;
      dma_start_o <= nxt_dma_start;
      if (any_wr) begin
        wr_lanes_o <= nxt_lanes;
        wr_data_o <= nxt_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ready_busy;
    @(posedge mclk_i) disable iff (!nrst_i)
      (running && in_mem) |=> (ready_irq_o == !$past(busy_i));
  endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("ready not tracking busy"); // see RQ1

  property p_init_low;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_ff == ST_INIT && in_mem) |=> !ready_irq_o;
  endproperty
  a_init_low: assert property (p_init_low) else $error("ready high during init"); // see RQ2

  property p_held_high;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_ff == ST_HELD && in_mem) |=> ready_irq_o;
  endproperty
  a_held_high: assert property (p_held_high) else $error("ready low while held"); // see RQ4

  property p_io_pulse;
    @(posedge mclk_i) disable iff (!nrst_i)
      (running && in_io && irq_pulse_mode_i && irq_rise) |=> ##1 !ready_irq_o;
  endproperty
  a_io_pulse: assert property (p_io_pulse) else $error("no interrupt pulse"); // see RQ5

  property p_io_level;
    @(posedge mclk_i) disable iff (!nrst_i)
      (in_io && !irq_pulse_mode_i) |=> (ready_irq_o == !$past(irq_i));
  endproperty
  a_io_level: assert property (p_io_level) else $error("level interrupt wrong"); // see RQ5

  property p_disk_irq;
    @(posedge mclk_i) disable iff (!nrst_i)
      in_disk |=> (ready_irq_o == $past(irq_i));
  endproperty
  a_disk_irq: assert property (p_disk_irq) else $error("disk interrupt wrong"); // see RQ6

  property p_wait_never;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_ff != ST_BOOT) |-> io_channel_ready_o;
  endproperty
  a_wait_never: assert property (p_wait_never) else $error("wait asserted"); // see RQ15

  property p_dma_acknowledge_n_ignored;
    @(posedge mclk_i) disable iff (!nrst_i)
      !dma_enable_i |=> (!dma_start_o && !dma_wr_o);
  endproperty
  a_dma_acknowledge_n_ignored: assert property (p_dma_acknowledge_n_ignored) else $error("dma_acknowledge_n used"); // see RQ10

  property p_disk_we_ignored;
    @(posedge mclk_i) disable iff (!nrst_i)
      in_disk |=> (!common_wr_o && !attr_wr_o);
  endproperty
  a_disk_we_ignored: assert property (p_disk_we_ignored) else $error("strobe used"); // see RQ18

  sequence s_init_done;
    st_ff == ST_INIT && !rst_act && init_cnt_ff == INIT_LAST;
  endsequence
  sequence s_enter_run;
    running ##1 !write_protect_o;
  endsequence
  property p_init_done;
    @(posedge mclk_i) disable iff (!nrst_i)
      s_init_done |=> s_enter_run;
  endproperty
  a_init_done: assert property (p_init_done) else $error("init not completed"); // see RQ19

  property p_reset_polarity;
    @(posedge mclk_i) disable iff (!nrst_i)
      (running && (disk_ff ? !rst_pin_s : rst_pin_s)) |=> (st_ff == ST_INIT);
  endproperty
  a_reset_polarity: assert property (p_reset_polarity) else $error("reset missed"); // see RQ12 see RQ14

  property p_wide;
    @(posedge mclk_i) disable iff (!nrst_i)
      (in_io || in_disk) |=> (wide_n_o == !$past(in_io ? port_wide_i : word_xfer_i));
  endproperty
  a_wide: assert property (p_wide) else $error("width indication wrong"); // see RQ20 see RQ21

endmodule // card_host_ctrl

// ---- src/card_host_pkg.sv ----
// Types of the card host control block.
// Assumes the constants header is included by the modules.
package card_host_pkg;

  typedef enum logic [1:0] {
    MODE_MEM = 2'b00,
    MODE_IO = 2'b01,
    MODE_DISK = 2'b10
  } card_mode_t;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_HELD = 2'b01,
    ST_INIT = 2'b10,
    ST_RUN = 2'b11
  } init_state_t;

endpackage

// ---- src/card_host_regs.svh ----
// Constants of the card host control block: timing counts and pin positions.
// Assumes a single 40 MHz clock and host pins brought in through a synchroniser.
//
// Function
// RQ1 - Ready low while busy, high when free
// RQ2 - Ready held low until initialisation completes
// RQ3 - Host waits while ready is low
// RQ4 - Powered up in reset: ready held high
// RQ5 - I/O mode interrupt: low pulse or level
// RQ6 - Disk mode interrupt is active-high level
// RQ7 - Space select: high common, low attribute
// RQ8 - Host holds space select low for I/O
// RQ9 - DMA acknowledge answers request, starts transfer
// RQ10 - DMA acknowledge ignored while DMA disabled
// RQ11 - Host without DMA holds acknowledge high
// RQ12 - Reset input active high in card modes
// RQ13 - Power-up reset only when reset pin high; in disk mode the code holds in reset when the pin is low
// RQ14 - Reset input active low in disk mode
// RQ15 - Wait line never asserted
// RQ16 - Memory mode write strobe captures write data
// RQ17 - I/O mode write strobe: configuration writes only
// RQ18 - Disk mode ignores write strobe
// RQ19 - Write protect low after initialisation
// RQ20 - I/O mode wide-port indication driven low
// RQ21 - Disk mode word-transfer indication driven low
// RQ22 - Two card enables pick byte lanes
// RQ23 - Disk mode selects off during DMA
// RQ24 - Mode select low picks disk mode
// RQ25 - I/O write data latched on strobe rise
// RQ26 - Host pins synchronised before use
`ifndef CARD_HOST_REGS_SVH
`define CARD_HOST_REGS_SVH

`define MCLK_PERIOD_NS 25
`define IRQ_PULSE_NS 500
`define IRQ_PULSE_CYC ((`IRQ_PULSE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define INIT_CYCLES_DEF 64
`define BOOT_CYCLES 3

// Positions in the synchronised pin vector
`define PIN_W 27
`define PIN_DATA_LSB 11
`define PIN_RST 10
`define PIN_DSEL 9
`define PIN_SPACE 8
`define PIN_CE_EVEN 7
`define PIN_CE_ODD 6
`define PIN_A0 5
`define PIN_WE 4
`define PIN_IO_WRITE_STROBE_N 3
`define PIN_DMA_ACKNOWLEDGE_N 2
`define PIN_CS0 1
`define PIN_CS1 0
// Idle levels: strobes and selects high, reset low, card modes selected
`define PIN_IDLE 27'h000_03DF

`endif

// ---- src/pin_sync.sv ----
// Two-stage synchroniser for a vector of host pins.
// Assumes the pins are asynchronous to mclk_i.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] pins_i,
  output logic [WIDTH-1:0] pins_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= pins_i; // see RQ26
      sync_ff <= meta_ff;
    end
  end

  assign pins_o = sync_ff;

endmodule // pin_sync

// ---- verif/flash_card_host_control_signals_tb.sv ----
// Bench for the card host control block with a host socket model.
// Assumes INIT_CYCLES 4 and PULSE_CYCLES 2; inputs change at falling edges.
`timescale 1ns/1ps
module flash_card_host_control_signals_tb;
  import card_host_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic io_mode = 1'b0, busy = 1'b0, irq = 1'b0, pmode = 1'b0;
  logic dma_en = 1'b0, dma_req = 1'b0, pwide = 1'b0, wxfer = 1'b0;
  logic card_reset, dsel_n, we_n, io_write_strobe_n_n, clr = 1'b0;
  logic [6:0] sel, seen;
  logic [15:0] data, wr_data;
  logic [1:0] card_mode, lanes;
  logic ready, wide_n, wp, chan_rdy;
  logic [6:0] pulse;
  int n_errors = 0, cmp_count = 0, cyc = 0;

  // ----------------------------------------
  // Clock, instances, pulse capture
  // ----------------------------------------
  always #12.5 mclk_i = ~mclk_i;

  host_socket_model i_host_socket_model (.mclk_i(mclk_i), .card_reset_o(card_reset),
    .dsel_n_o(dsel_n), .sel_o(sel), .we_n_o(we_n), .io_write_strobe_n_n_o(io_write_strobe_n_n), .data_o(data));

  card_host_ctrl #(.INIT_CYCLES(4), .PULSE_CYCLES(2)) i_card_host_ctrl (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .card_reset_i(card_reset),
    .disk_mode_select_n_i(dsel_n), .space_select_n_i(sel[6]),
    .card_enable_even_n_i(sel[5]), .card_enable_odd_n_i(sel[4]), .addr0_i(sel[3]),
    .write_enable_n_i(we_n), .io_write_strobe_n_i(io_write_strobe_n_n), .dma_acknowledge_n_i(sel[0]),
    .task_file_select_n_i(sel[2]), .control_block_select_n_i(sel[1]), .host_data_i(data),
    .io_mode_i(io_mode), .busy_i(busy), .irq_i(irq), .irq_pulse_mode_i(pmode),
    .dma_enable_i(dma_en), .dma_request_i(dma_req), .port_wide_i(pwide),
    .word_xfer_i(wxfer), .ready_irq_o(ready), .wide_n_o(wide_n), .write_protect_o(wp),
    .io_channel_ready_o(chan_rdy), .card_mode_o(card_mode), .common_wr_o(pulse[6]),
    .attr_wr_o(pulse[5]), .io_reg_wr_o(pulse[4]), .task_file_wr_o(pulse[3]),
    .control_block_wr_o(pulse[2]), .dma_wr_o(pulse[1]), .dma_start_o(pulse[0]),
    .wr_lanes_o(lanes), .wr_data_o(wr_data));

  always @(posedge mclk_i) begin
    seen <= clr ? 7'h00 : (seen | pulse);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic results();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (2) @(negedge mclk_i);
  endtask

  task automatic wait_init();
    int i;
    for (i = 0; i < 40 && wp !== 1'b0; i++) begin
      @(negedge mclk_i);
      if (dsel_n === 1'b1 && io_mode === 1'b0 && wp === 1'b1) chk(ready, 1'b0);
    end
    chk(wp, 1'b0);
    chk(i < 12, 1'b1);
  endtask

  task automatic boot(input logic rst, input logic dsel, input logic held);
    @(negedge mclk_i);
    nrst_i = 1'b0;
    i_host_socket_model.pins(rst, dsel);
    repeat (8) @(negedge mclk_i);
    nrst_i = 1'b1;
    if (!held) wait_init();
  endtask

  task automatic wr(input logic io, input logic [6:0] s, input logic [15:0] d,
                    input logic [6:0] e_seen, input logic [1:0] e_ln, input logic [15:0] e_d);
    @(negedge mclk_i);
    clr = 1'b1;
    @(negedge mclk_i);
    clr = 1'b0;
    i_host_socket_model.write(io, s, d);
    repeat (3) @(negedge mclk_i);
    chk(seen, e_seen);
    if (e_seen != 7'h00) begin
      chk(lanes, e_ln);
      chk(wr_data, e_d);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_mem();
    boot(1'b0, 1'b1, 1'b0);
    chk(card_mode, MODE_MEM);
    chk(chan_rdy, 1'b1);
    busy = 1'b1;
    settle();
    chk(ready, 1'b0);
    busy = 1'b0;
    settle();
    chk(ready, 1'b1);
    wr(1'b0, 7'h47, 16'h3C5A, 7'h40, 2'h3, 16'h3C5A);
    wr(1'b0, 7'h1F, 16'h12A5, 7'h20, 2'h2, 16'hA5A5);
    wr(1'b0, 7'h67, 16'h4321, 7'h40, 2'h2, 16'h4321);
    wr(1'b0, 7'h57, 16'h8765, 7'h40, 2'h1, 16'h8765);
  endtask

  task automatic t_held();
    boot(1'b1, 1'b1, 1'b1);
    repeat (8) @(negedge mclk_i);
    chk(ready, 1'b1);
    chk(wp, 1'b1);
    i_host_socket_model.pins(1'b0, 1'b1);
    // Ready stays high until the released pin has crossed the synchroniser
    settle();
    settle();
    wait_init();
    i_host_socket_model.pins(1'b1, 1'b1);
    settle();
    settle();
    chk(wp, 1'b1);
    chk(ready, 1'b0);
    i_host_socket_model.pins(1'b0, 1'b1);
    wait_init();
  endtask

  task automatic t_io();
    logic [3:0] n;
    int i;
    io_mode = 1'b1;
    pwide = 1'b1;
    settle();
    settle();
    chk(card_mode, MODE_IO);
    chk(wide_n, 1'b0);
    chk(ready, 1'b1);
    wr(1'b1, 7'h07, 16'hBEEF, 7'h10, 2'h3, 16'hBEEF);
    wr(1'b0, 7'h47, 16'h1111, 7'h00, 2'h0, 16'h0000);
    wr(1'b0, 7'h07, 16'h2222, 7'h20, 2'h3, 16'h2222);
    pmode = 1'b1;
    irq = 1'b1;
    n = 4'h0;
    for (i = 0; i < 10; i++) begin
      @(negedge mclk_i);
      n = n + {3'h0, ready === 1'b0};
    end
    chk(n, 4'h2);
    irq = 1'b0;
    pmode = 1'b0;
    settle();
    irq = 1'b1;
    settle();
    repeat (5) @(negedge mclk_i);
    chk(ready, 1'b0);
    irq = 1'b0;
    pwide = 1'b0;
    io_mode = 1'b0;
  endtask

  task automatic t_disk();
    boot(1'b1, 1'b0, 1'b0);
    chk(card_mode, MODE_DISK);
    chk(ready, 1'b0);
    irq = 1'b1;
    settle();
    chk(ready, 1'b1);
    irq = 1'b0;
    wxfer = 1'b1;
    settle();
    chk(wide_n, 1'b0);
    wxfer = 1'b0;
    settle();
    chk(wide_n, 1'b1);
    wr(1'b0, 7'h73, 16'h0101, 7'h00, 2'h0, 16'h0000);
    wr(1'b1, 7'h73, 16'h0A0B, 7'h08, 2'h3, 16'h0A0B);
    wr(1'b1, 7'h75, 16'h0C0D, 7'h04, 2'h3, 16'h0C0D);
    dma_req = 1'b1;
    wr(1'b1, 7'h76, 16'h5555, 7'h00, 2'h0, 16'h0000);
    dma_en = 1'b1;
    // Both selects stay high while the acknowledge is driven
    wr(1'b1, 7'h76, 16'h6789, 7'h03, 2'h3, 16'h6789);
    dma_req = 1'b0;
    chk(chan_rdy, 1'b1);
    i_host_socket_model.pins(1'b0, 1'b0);
    settle();
    settle();
    chk(wp, 1'b1);
    i_host_socket_model.pins(1'b1, 1'b0);
    wait_init();
  endtask

  initial begin
    t_mem();
    t_io();
    t_held();
    t_disk();
    results();
  end
endmodule // flash_card_host_control_signals_tb

// ---- verif/host_socket_model.sv ----
// Host socket model: drives the card's host pins for write cycles.
// Assumes one bench process calls its tasks; pins change at falling edges.
`timescale 1ns/1ps
module host_socket_model (
  input wire logic mclk_i,
  output logic card_reset_o,
  output logic dsel_n_o,
  output logic [6:0] sel_o,
  output logic we_n_o,
  output logic io_write_strobe_n_n_o,
  output logic [15:0] data_o
);
  // ----------------------------------------
  // Pins; sel_o is {space, even, odd, a0, task file, control, dma ack}
  // ----------------------------------------
  initial begin
    card_reset_o = 1'b0;
    dsel_n_o = 1'b1;
    sel_o = 7'h77;
    we_n_o = 1'b1;
    io_write_strobe_n_n_o = 1'b1;
    data_o = 16'h0000;
  end

  task automatic pins(input logic rst, input logic dsel);
    @(negedge mclk_i);
    card_reset_o = rst;
    dsel_n_o = dsel;
  endtask

  // Strobe low 3 and high 4 cycles, above the 2-cycle synchroniser minimum
  task automatic write(input logic io, input logic [6:0] sel, input logic [15:0] d);
    @(negedge mclk_i);
    sel_o = sel;
    data_o = d;
    if (io) begin
      io_write_strobe_n_n_o = 1'b0;
    end else begin
      we_n_o = 1'b0;
    end
    repeat (3) @(negedge mclk_i);
    io_write_strobe_n_n_o = 1'b1;
    we_n_o = 1'b1;
    repeat (4) @(negedge mclk_i);
    sel_o = 7'h77;
    // Released bus shows no stale value
    data_o = ~d;
  endtask
endmodule // host_socket_model
